// ==== design/adc_scan_map.svh ====
`ifndef ADC_SCAN_MAP_SVH
`define ADC_SCAN_MAP_SVH

// Register bus geometry.
`define REG_ADDR_W      2
`define REG_DATA_W      16

// Register word offsets on the plain register port.
`define ADDR_CTRL       2'h0
`define ADDR_HIT_LO     2'h1
`define ADDR_HIT_HI     2'h2

// Writable bits of the control word: 15:11, 9:8 and 3:0.
`define CTRL_WMASK      16'hfb0f

// Reset values.
`define CTRL_RESET      16'h0000
`define HIT_RESET       32'h0000_0000

// Channel limits of the compare-hit flag set.
`define CHAN_MAX        32
`define CHAN_DEF        18

`endif

// ==== design/adc_scan_pkg.sv ====
`default_nettype none

package adc_scan_pkg;

    // Compare selection codes.
    typedef enum logic [1:0] {
        CMP_LESS    = 2'h0,
        CMP_GREATER = 2'h1,
        CMP_INSIDE  = 2'h2,
        CMP_OUTSIDE = 2'h3
    } cmp_mode_t;

    // Result write selection codes.
    typedef enum logic [1:0] {
        WR_LEGACY   = 2'h0,
        WR_SAVE     = 2'h1,
        WR_AUTO     = 2'h2,
        WR_RSVD     = 2'h3
    } write_mode_t;

    // Scan interrupt selection codes.
    typedef enum logic [1:0] {
        INT_NONE    = 2'h0,
        INT_DONE    = 2'h1,
        INT_MATCH   = 2'h2,
        INT_BOTH    = 2'h3
    } int_mode_t;

    // Layout of the scan-compare control word, bit 15 first.
    typedef struct packed {
        logic        auto_scan_enable;
        logic        low_power_return;
        logic        charge_timer_request;
        logic        bandgap_request;
        logic        reserved;
        logic        unused_10;
        int_mode_t   scan_interrupt_select;
        logic [3:0]  unused_7_4;
        write_mode_t result_write_select;
        cmp_mode_t   compare_select;
    } ctrl_t;

    // One conversion result with its channel.
    typedef struct packed {
        logic [4:0]  chan;
        logic [15:0] result;
    } conv_t;

    // The buffer pair that bounds the channel's compare.
    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
    } bounds_t;

endpackage : adc_scan_pkg

`default_nettype wire

// ==== design/adc_scan_threshold_compare.sv ====
// Implementation choices: the placing of the registers and the plain strobed port.
`include "adc_scan_map.svh"
`timescale 1ns/10ps
`default_nettype none

module adc_scan_threshold_compare #(
    parameter int NUM_CHAN = `CHAN_DEF
) (
    // Clock and reset.
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_n_in,
    // Register port.
    input  wire logic [`REG_ADDR_W-1:0]     reg_addr_in,
    input  wire logic [`REG_DATA_W-1:0]     reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [`REG_DATA_W-1:0]     reg_rdata_out,
    // Conversion engine side.
    input  wire logic                       conv_valid_in,
    input  wire adc_scan_pkg::conv_t        conv_in,
    input  wire adc_scan_pkg::bounds_t      bounds_in,
    input  wire logic                       scan_done_in,
    input  wire logic                       adc_enabled_in,
    input  wire logic                       adc_active_in,
    // Result store strobe towards the buffers.
    output logic                            store_valid_out,
    output var adc_scan_pkg::conv_t         store_out,
    // Scan event and power controls.
    output logic                            scan_irq_out,
    output logic                            auto_scan_enable_out,
    output logic                            low_power_out,
    output logic                            charge_time_unit_en_out,
    output logic                            bandgap_en_out
);

    // Parameter check at elaboration.
    if (NUM_CHAN < 1 || NUM_CHAN > `CHAN_MAX) begin : g_bad_chan
        $error("NUM_CHAN must lie between 1 and 32");
    end

    // Reset release synchroniser.
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n);

    // Register state.
    adc_scan_pkg::ctrl_t  ctrl_q;
    logic [NUM_CHAN-1:0]  hit_q;
    logic [NUM_CHAN-1:0]  hit_d;
    logic                 seen_q;

    // Register decode.
    wire wr_ctrl   = reg_wr_in && (reg_addr_in == `ADDR_CTRL);
    wire wr_hit_lo = reg_wr_in && (reg_addr_in == `ADDR_HIT_LO);
    wire wr_hit_hi = reg_wr_in && (reg_addr_in == `ADDR_HIT_HI);
    wire [31:0] hit_ext = 32'(hit_q);

    // Control fields in use.
    wire scan_on = ctrl_q.auto_scan_enable;
    wire adc_up  = adc_enabled_in && adc_active_in;
    adc_scan_pkg::cmp_mode_t   cm;
    adc_scan_pkg::write_mode_t wm;
    adc_scan_pkg::int_mode_t   im;
    assign cm = ctrl_q.compare_select;
    assign wm = ctrl_q.result_write_select;
    assign im = ctrl_q.scan_interrupt_select;

    // Compare of the result against the channel's buffer pair.
    wire [15:0] res   = conv_in.result;
    wire lt_lo        = res < bounds_in.lo;
    wire gt_lo        = res > bounds_in.lo;
    wire in_win       = (res >= bounds_in.lo) && (res <= bounds_in.hi);
    wire match_lt     = (cm == adc_scan_pkg::CMP_LESS)    && lt_lo;
    wire match_gt     = (cm == adc_scan_pkg::CMP_GREATER) && gt_lo;
    wire match_in     = (cm == adc_scan_pkg::CMP_INSIDE)  && in_win;
    wire match_out    = (cm == adc_scan_pkg::CMP_OUTSIDE) && !in_win;
    wire match_any    = match_lt || match_gt || match_in || match_out;
    wire scan_conv    = conv_valid_in && scan_on;
    wire valid_match  = scan_conv && match_any;

    // Store decision; without the scan every result is stored.
    wire wm_legacy    = (wm == adc_scan_pkg::WR_LEGACY);
    wire wm_save      = (wm == adc_scan_pkg::WR_SAVE);
    wire store_legacy = conv_valid_in && (!scan_on || wm_legacy);
    wire store_match  = scan_conv && wm_save && match_any;
    wire store_d      = store_legacy || store_match;

    // Hit flag set vector; in outside mode a buffer write also sets it.
    wire buf_written  = store_d && (cm == adc_scan_pkg::CMP_OUTSIDE);
    wire hit_event    = valid_match || (scan_conv && buf_written);
    wire [NUM_CHAN-1:0] hit_set =
        hit_event ? (NUM_CHAN'(1) << conv_in.chan) : '0;

    // Software write merge; a flag set by hardware wins the same cycle.
    wire [15:0] hit_lo_w = wr_hit_lo ? reg_wdata_in : hit_ext[15:0];
    wire [15:0] hit_hi_w = wr_hit_hi ? reg_wdata_in : hit_ext[31:16];
    assign hit_d = NUM_CHAN'({hit_hi_w, hit_lo_w}) | hit_set;

    // Scan interrupt selection.
    wire seq_end  = scan_done_in && scan_on;
    wire irq_done = (im == adc_scan_pkg::INT_DONE) && seq_end;
    wire irq_mat  = (im == adc_scan_pkg::INT_MATCH) && valid_match;
    wire irq_both = (im == adc_scan_pkg::INT_BOTH) && seq_end &&
                    (seen_q || valid_match);
    wire irq_d    = irq_done || irq_mat || irq_both;

    // Read data selection; unmapped words and unused bits read zero.
    logic [15:0] rd_mux;
    assign rd_mux = (reg_addr_in == `ADDR_CTRL)   ? 16'(ctrl_q)   :
                    (reg_addr_in == `ADDR_HIT_LO) ? hit_ext[15:0] :
                    (reg_addr_in == `ADDR_HIT_HI) ? hit_ext[31:16] :
                    16'h0000;

    // Control register; unimplemented bits never store a one.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= adc_scan_pkg::ctrl_t'(`CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_q <= adc_scan_pkg::ctrl_t'(reg_wdata_in & `CTRL_WMASK);
        end
    end

    // Compare-hit flags.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            hit_q <= NUM_CHAN'(`HIT_RESET);
        end else begin
            hit_q <= hit_d;
        end
    end

    // Match seen during the current sequence, consumed at its end.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
        end else if (seq_end || !scan_on) begin
            seen_q <= 1'b0;
        end else if (valid_match) begin
            seen_q <= 1'b1;
        end
    end

    // Read data stands for the one cycle after the strobe.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
        end
    end

    // Result store strobe and interrupt pulse.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            store_valid_out <= 1'b0;
            store_out       <= '0;
            scan_irq_out    <= 1'b0;
        end else begin
            store_valid_out <= store_d;
            store_out       <= conv_in;
            scan_irq_out    <= irq_d;
        end
    end

    // Low-power state entered after a scan when chosen, left on activity.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            low_power_out <= 1'b0;
        end else if (seq_end && ctrl_q.low_power_return) begin
            low_power_out <= 1'b1;
        end else if (adc_active_in || !ctrl_q.low_power_return) begin
            low_power_out <= 1'b0;
        end
    end

    // Requests to the charge timer and band gap, and the enable echo.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            charge_time_unit_en_out <= 1'b0;
            bandgap_en_out          <= 1'b0;
            auto_scan_enable_out    <= 1'b0;
        end else begin
            charge_time_unit_en_out <= ctrl_q.charge_timer_request && adc_up;
            bandgap_en_out          <= ctrl_q.bandgap_request && adc_up;
            auto_scan_enable_out    <= scan_on;
        end
    end

    // Checks on the block's own behaviour.
    a_scan_enable_echo: assert property (
        ctrl_q.auto_scan_enable |=> auto_scan_enable_out)
        else $error("scan enable not passed to output");

    a_scan_disable_echo: assert property (
        !ctrl_q.auto_scan_enable |=> !auto_scan_enable_out)
        else $error("scan disable not passed to output");

    a_scan_off_flags: assert property (
        !scan_on && !wr_hit_lo && !wr_hit_hi |=> hit_q == $past(hit_q))
        else $error("hit flags changed with the scan off");

    a_low_power_enter: assert property (
        seq_end && ctrl_q.low_power_return |=> low_power_out)
        else $error("no low-power return after scan");

    a_low_power_leave: assert property (
        !ctrl_q.low_power_return |=> !low_power_out)
        else $error("low power held with return bit clear");

    a_charge_timer_req: assert property (
        charge_time_unit_en_out == $past(ctrl_q.charge_timer_request && adc_up))
        else $error("charge timer enable wrong");

    a_bandgap_req: assert property (
        adc_up && !ctrl_q.bandgap_request |=> !bandgap_en_out)
        else $error("band gap enabled without request");

    a_bandgap_on: assert property (
        adc_up && ctrl_q.bandgap_request |=> bandgap_en_out)
        else $error("band gap not enabled on request");

    a_unused_read_zero: assert property (
        reg_rd_in && reg_addr_in == `ADDR_CTRL
        |=> reg_rdata_out[10] == 1'b0 && reg_rdata_out[7:4] == 4'h0)
        else $error("unimplemented control bits read nonzero");

    a_ctrl_unused_zero: assert property (
        ctrl_q.unused_10 == 1'b0 && ctrl_q.unused_7_4 == 4'h0)
        else $error("unimplemented control bits stored a one");

    a_unmapped_read_zero: assert property (
        reg_rd_in && reg_addr_in != `ADDR_CTRL && reg_addr_in != `ADDR_HIT_LO
        && reg_addr_in != `ADDR_HIT_HI |=> reg_rdata_out == 16'h0000)
        else $error("unmapped word read nonzero");

    a_int_never: assert property (
        im == adc_scan_pkg::INT_NONE |=> !scan_irq_out)
        else $error("interrupt raised with none selected");

    a_int_seq_done: assert property (
        im == adc_scan_pkg::INT_DONE && seq_end |=> scan_irq_out)
        else $error("no interrupt at sequence end");

    a_int_done_quiet: assert property (
        im == adc_scan_pkg::INT_DONE && !seq_end |=> !scan_irq_out)
        else $error("done interrupt without sequence end");

    a_int_on_match: assert property (
        im == adc_scan_pkg::INT_MATCH && scan_conv && cm == adc_scan_pkg::CMP_GREATER
        && conv_in.result > bounds_in.lo |=> scan_irq_out)
        else $error("no interrupt on valid compare");

    a_int_both_done: assert property (
        im == adc_scan_pkg::INT_BOTH && seq_end && valid_match |=> scan_irq_out)
        else $error("no interrupt at sequence end after a match");

    a_int_both_quiet: assert property (
        im == adc_scan_pkg::INT_BOTH && !seq_end |=> !scan_irq_out)
        else $error("interrupt before sequence end");

    a_auto_no_store: assert property (
        scan_on && wm == adc_scan_pkg::WR_AUTO |=> !store_valid_out)
        else $error("result stored in auto-compare mode");

    a_auto_irq_kept: assert property (
        scan_on && wm == adc_scan_pkg::WR_AUTO && im == adc_scan_pkg::INT_MATCH
        && valid_match |=> scan_irq_out)
        else $error("auto-compare mode lost its interrupt");

    a_reserved_no_store: assert property (
        scan_on && wm == adc_scan_pkg::WR_RSVD |=> !store_valid_out)
        else $error("result stored in reserved write mode");

    a_save_on_match: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_LESS && lt_lo
        |=> store_valid_out && store_out == $past(conv_in))
        else $error("matching result not stored");

    a_save_less_miss: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_LESS
        && conv_in.result >= bounds_in.lo |=> !store_valid_out)
        else $error("result not below bound stored");

    a_save_no_match: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_GREATER && !gt_lo
        |=> !store_valid_out)
        else $error("non-matching result stored");

    a_save_greater: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_GREATER
        && conv_in.result > bounds_in.lo |=> store_valid_out)
        else $error("result above bound not stored");

    a_inside_hit: assert property (
        scan_conv && cm == adc_scan_pkg::CMP_INSIDE && in_win
        && {1'b0, conv_in.chan} < 6'(NUM_CHAN)
        |=> hit_q[$past(conv_in.chan)])
        else $error("inside match flag not set");

    a_inside_miss: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_INSIDE
        && (conv_in.result < bounds_in.lo || conv_in.result > bounds_in.hi)
        |=> !store_valid_out)
        else $error("result outside window stored in inside mode");

    a_outside_hit: assert property (
        scan_conv && cm == adc_scan_pkg::CMP_OUTSIDE && !in_win
        && {1'b0, conv_in.chan} < 6'(NUM_CHAN)
        |=> hit_q[$past(conv_in.chan)] && scan_irq_out == $past(irq_d))
        else $error("outside match flag not set");

    a_outside_store: assert property (
        scan_conv && wm_save && cm == adc_scan_pkg::CMP_OUTSIDE
        && conv_in.result > bounds_in.hi |=> store_valid_out)
        else $error("result beyond window not stored");

    a_hit_sticky: assert property (
        hit_q[0] && !(wr_hit_lo && !reg_wdata_in[0]) |=> hit_q[0])
        else $error("compare hit flag lost");

    a_legacy_store: assert property (
        conv_valid_in && (!scan_on || wm_legacy) |=> store_valid_out)
        else $error("legacy result not stored");

endmodule : adc_scan_threshold_compare

`default_nettype wire

// ==== tb/adc_scan_threshold_compare_tb.sv ====
`include "adc_scan_map.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module adc_scan_threshold_compare_tb;
    // Stimulus, observed outputs and the reference model's state.
    logic                  clk_sys_in = 1'b0;
    logic                  rst_n_in   = 1'b0;
    logic [1:0]            addr       = 2'h0;
    logic [15:0]           wdata      = 16'h0000;
    logic                  wr         = 1'b0;
    logic                  rd         = 1'b0;
    logic                  cv         = 1'b0;
    adc_scan_pkg::conv_t   conv       = '0;
    adc_scan_pkg::bounds_t bnd        = '0;
    logic                  done       = 1'b0;
    logic                  en         = 1'b0;
    logic                  act        = 1'b0;
    logic [15:0]           rdata;
    logic                  st_v, irq, ase, lp, ctm, bg;
    adc_scan_pkg::conv_t   st;
    int                    n_errors   = 0;
    int                    n_tests    = 0;
    logic [31:0]           lfsr_q     = 32'h1ef3;
    logic [15:0]           ctrl_m     = 16'h0000;
    logic [31:0]           hit_m      = 32'h0000_0000;
    logic                  pend_m     = 1'b0;

    // System clock at 100 MHz.
    always #5 clk_sys_in = ~clk_sys_in;

    // Block under test with its default channel count.
    adc_scan_threshold_compare #(.NUM_CHAN(`CHAN_DEF)) i_adc_scan_threshold_compare (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .conv_valid_in(cv), .conv_in(conv), .bounds_in(bnd), .scan_done_in(done),
        .adc_enabled_in(en), .adc_active_in(act), .store_valid_out(st_v),
        .store_out(st), .scan_irq_out(irq), .auto_scan_enable_out(ase),
        .low_power_out(lp), .charge_time_unit_en_out(ctm), .bandgap_en_out(bg));

    // Pseudo-random source for results, bounds and channels.
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    // Reference compare, unsigned, lower bound used by the single-sided modes.
    function automatic logic hit_of(logic [1:0] cm, logic [15:0] r, logic [15:0] lo,
                                    logic [15:0] hi);
        case (cm)
            2'h0:    return r < lo;
            2'h1:    return r > lo;
            2'h2:    return (r >= lo) && (r <= hi);
            default: return (r < lo) || (r > hi);
        endcase
    endfunction : hit_of

    // One register write; the model follows the writable bits.
    task automatic wreg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        if (a == 2'h0) ctrl_m = d & 16'hfb0f;
        if (a == 2'h0 && !d[15]) pend_m = 1'b0;
        if (a == 2'h1) hit_m[15:0] = d;
        if (a == 2'h2) hit_m[31:16] = d;
        hit_m &= (32'h1 << `CHAN_DEF) - 32'h1;
    endtask : wreg

    // One register read; data is taken in the cycle after the strobe.
    task automatic rreg(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rreg

    // One random conversion, optionally with the end-of-sequence pulse.
    task automatic cvt(input logic d);
        logic [31:0] r;
        logic        m, sc, xs, xi, hw;
        logic [1:0]  wm, sel;
        r = rnd();
        @(posedge clk_sys_in);
        cv   <= 1'b1;
        conv <= {r[20:16], 8'h00, r[7:0]};
        bnd  <= {8'h00, r[15:8], 8'h00, r[31:24]};
        done <= d;
        @(posedge clk_sys_in);
        cv   <= 1'b0;
        done <= 1'b0;
        sc   = ctrl_m[15];
        wm   = ctrl_m[3:2];
        sel  = ctrl_m[9:8];
        m    = sc && hit_of(ctrl_m[1:0], {8'h00, r[7:0]}, {8'h00, r[15:8]}, {8'h00, r[31:24]});
        xs   = !sc || wm == 2'h0 || (wm == 2'h1 && m);
        xi   = sc && (sel == 2'h2 ? m : sel == 2'h1 ? d : sel == 2'h3 ? d && (pend_m || m) : 1'b0);
        pend_m = sc && !d && (pend_m || m);
        hw   = m || (sc && ctrl_m[1:0] == 2'h3 && xs);
        if (hw && r[20:16] < `CHAN_DEF) hit_m[r[20:16]] = 1'b1;
        #1;
        `CHK(st_v, xs)
        `CHK(irq, xi)
        if (xs) `CHK(st, conv)
    endtask : cvt

    // Prints the counts and the verdict, then stops the run.
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Watchdog far beyond the expected few hundred cycles.
    initial begin
        #200000;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end

    // Main sequence of tests.
    initial begin
        logic [15:0] v;
        int          i, k;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        rreg(2'h0, v);
        `CHK(v, 16'h0000)
        rreg(2'h1, v);
        `CHK(v, 16'h0000)
        `CHK({ase, lp, ctm, bg, irq, st_v}, 6'h00)
        $display("test reset done");
        wreg(2'h0, 16'hffff);
        @(posedge clk_sys_in);
        #1 `CHK(ase, 1'b1)
        rreg(2'h0, v);
        `CHK(v, 16'hfb0f)
        wreg(2'h0, 16'h0000);
        @(posedge clk_sys_in);
        #1 `CHK(ase, 1'b0)
        rreg(2'h3, v);
        `CHK(v, 16'h0000)
        wreg(2'h2, 16'hffff);
        rreg(2'h2, v);
        `CHK(v, hit_m[31:16])
        wreg(2'h2, 16'h0000);
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            wreg(2'h0, {2'b00, i[1:0], 12'h000});
            en  <= i[2];
            act <= i[3];
            repeat (2) @(posedge clk_sys_in);
            #1 `CHK(ctm, i[1] & i[2] & i[3])
            `CHK(bg, i[0] & i[2] & i[3])
        end
        en  <= 1'b1;
        act <= 1'b0;
        $display("test requests done");
        for (i = 0; i < 2; i++) begin
            wreg(2'h0, {1'b1, i[0], 14'h0000});
            cvt(1'b1);
            `CHK(lp, i[0])
        end
        $display("test low power done");
        // Every scan, interrupt and write mode mix, compare mode random.
        for (i = 0; i < 32; i++) begin
            wreg(2'h0, 16'h0000);
            wreg(2'h0, {i[4], 5'h00, i[1:0], 4'h0, i[3:2], 2'(rnd())});
            for (k = 0; k < 4; k++) cvt(k[0]);
        end
        rreg(2'h1, v);
        `CHK(v, hit_m[15:0])
        rreg(2'h2, v);
        `CHK(v, hit_m[31:16])
        $display("test modes done");
        for (i = 0; i < 4; i++) begin
            wreg(2'h1, 16'h0000);
            wreg(2'h2, 16'h0000);
            wreg(2'h0, {8'h82, 4'h0, 2'h1, i[1:0]});
            for (k = 0; k < 8; k++) cvt(1'b0);
            rreg(2'h1, v);
            `CHK(v, hit_m[15:0])
            rreg(2'h2, v);
            `CHK(v, hit_m[31:16])
        end
        $display("test compare flags done");
        print_verdict();
    end

endmodule : adc_scan_threshold_compare_tb
`default_nettype wire
